// ---- pkg/cic_params.svh ----
// Purpose: offsets, field positions, reset values for core/interrupt config block
// Assumes: word-addressed data space, 16-bit registers
// Notes: offsets are local indices within the block's data-space window
`ifndef CIC_PARAMS_SVH
`define CIC_PARAMS_SVH

`define CIC_ADDR_W 4
`define CIC_OFF_CORE_CONTROL 4'h0
`define CIC_OFF_INT_CONTROL_SECOND 4'h1
`define CIC_OFF_PRIORITY_ADC_SERIAL_TX 4'h2
`define CIC_OFF_PRIORITY_CRC_SERIAL_ERR 4'h3

`define CIC_CORE_LEVEL_BIT 3
`define CIC_CORE_PROGWIN_BIT 2
`define CIC_INTC2_ALTVEC_BIT 15
`define CIC_INTC2_TIMEDBLK_BIT 14
`define CIC_INTC2_EDGE_LSB 0
`define CIC_INTC2_EDGE_MASK 16'h001f
`define CIC_PRIORITY_ADC_SERIAL_TX_MASK 16'h0077
`define CIC_PRIORITY_CRC_SERIAL_ERR_MASK 16'h7770

`define CIC_PRIO_RESET 3'h4
`define CIC_PRIORITY_ADC_SERIAL_TX_ADC_LSB 4
`define CIC_PRIORITY_ADC_SERIAL_TX_TX_LSB 0
`define CIC_PRIORITY_CRC_SERIAL_ERR_CRC_LSB 12
`define CIC_PRIORITY_CRC_SERIAL_ERR_U2E_LSB 8
`define CIC_PRIORITY_CRC_SERIAL_ERR_U1E_LSB 4
`define CIC_LEVEL_SEVEN 4'h7

`endif

// ---- pkg/cic_pkg.sv ----
// Purpose: types shared by the core/interrupt config block
// Assumes: five priority-steered sources, five external edge inputs
// Notes: none
package cic_pkg;
  localparam int CIC_NUM_SRC = 5;
  localparam int CIC_NUM_EXT = 5;
  localparam int CIC_NUM_TRAP = 8;

  typedef logic [2:0] cic_prio_t;
  typedef logic [15:0] cic_word_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    cic_word_t wdata;
  } cic_bus_s;

  typedef struct packed {
    logic valid;
    logic is_trap;
    logic [3:0] id;
    cic_prio_t level;
  } cic_req_s;

  typedef enum logic [1:0] {
    CIC_EDGE_IDLE,
    CIC_EDGE_ARMED
  } cic_edge_e;
endpackage : cic_pkg

// ---- src/cic_core.sv ----
// Purpose: core control and interrupt configuration registers with priority arbitration
// Assumes: data-space register port from the CPU; one clock, synchronous reset
// Notes: arbitration is combinational; request output is registered
// How it works
// - all four registers sit in data space, read and written by ordinary accesses
// - core control bit 3 reads 1 when cpu level exceeds seven; clears itself once the level is seven or below
// - while that status bit is 1, no maskable request reaches the core
// - core control bit 2 shows program memory in data space; resets to 0
// - unimplemented bits read zero and ignore writes
// - three-bit priority codes give the level directly, 111 highest, 001 lowest
// - a priority code of 000 disables its source completely
// - third priority register bits 6-4 hold converter-done priority, reset 4
// - third priority register bits 2-0 hold serial1 transmit priority, reset 4
// - each source takes one of seven levels; arbitration picks the highest
// - up to eight traps run above level seven, unaffected by the user block
`timescale 1ns/1ps
`include "cic_params.svh"
module cic_core
#(
  parameter int NUM_TRAP = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input cic_pkg::cic_bus_s bus,
  output cic_pkg::cic_word_t rdata,
  input wire logic [3:0] cpu_level,
  input wire logic timed_irq_block_active,
  input wire logic [cic_pkg::CIC_NUM_SRC-1:0] src_flag,
  input wire logic [cic_pkg::CIC_NUM_EXT-1:0] ext_pin,
  input wire logic [NUM_TRAP-1:0] trap_flag,
  output logic [cic_pkg::CIC_NUM_EXT-1:0] ext_flag,
  output logic program_window_enable,
  output logic alternate_vector_select,
  output cic_pkg::cic_req_s core_req
);
  import cic_pkg::*;

  // trap ids travel in a 4-bit field and the trap scan is sized by NUM_TRAP, which must stay within the package limit
  if (NUM_TRAP < 1 || NUM_TRAP > CIC_NUM_TRAP)
  begin : g_bad_num_trap
    $error("NUM_TRAP must be 1..8");
  end

  logic cpu_level_above_seven;
  logic [CIC_NUM_EXT-1:0] ext_edge_polarity;
  cic_prio_t converter_done_priority;
  cic_prio_t serial1_tx_priority;
  cic_prio_t checksum_engine_priority;
  cic_prio_t serial2_error_priority;
  cic_prio_t serial1_error_priority;
  logic [CIC_NUM_EXT-1:0] ext_edge;
  cic_prio_t src_prio [CIC_NUM_SRC];
  cic_req_s next_req;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = bus.wr && ce && (a == off);
  endfunction : hit

  // level status tracks the cpu each cycle; a software write of 0 changes nothing, the bit falls whenever the cpu is seven or below
  always_ff @(posedge clk)
  begin
    if (rst)
      cpu_level_above_seven <= 1'b0;
    else if (ce)
    begin
      if (cpu_level > `CIC_LEVEL_SEVEN)
        cpu_level_above_seven <= 1'b1;
      else if (hit(bus.addr, `CIC_OFF_CORE_CONTROL) && !bus.wdata[`CIC_CORE_LEVEL_BIT])
        cpu_level_above_seven <= 1'b0;
      else
        cpu_level_above_seven <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      program_window_enable <= 1'b0;
    else if (hit(bus.addr, `CIC_OFF_CORE_CONTROL))
      program_window_enable <= bus.wdata[`CIC_CORE_PROGWIN_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alternate_vector_select <= 1'b0;
      ext_edge_polarity <= '0;
    end
    else if (hit(bus.addr, `CIC_OFF_INT_CONTROL_SECOND))
    begin
      alternate_vector_select <= bus.wdata[`CIC_INTC2_ALTVEC_BIT];
      ext_edge_polarity <= bus.wdata[`CIC_INTC2_EDGE_LSB +: CIC_NUM_EXT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      converter_done_priority <= `CIC_PRIO_RESET;
      serial1_tx_priority <= `CIC_PRIO_RESET;
    end
    else if (hit(bus.addr, `CIC_OFF_PRIORITY_ADC_SERIAL_TX))
    begin
      converter_done_priority <= bus.wdata[`CIC_PRIORITY_ADC_SERIAL_TX_ADC_LSB +: 3];
      serial1_tx_priority <= bus.wdata[`CIC_PRIORITY_ADC_SERIAL_TX_TX_LSB +: 3];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      checksum_engine_priority <= `CIC_PRIO_RESET;
      serial2_error_priority <= `CIC_PRIO_RESET;
      serial1_error_priority <= `CIC_PRIO_RESET;
    end
    else if (hit(bus.addr, `CIC_OFF_PRIORITY_CRC_SERIAL_ERR))
    begin
      checksum_engine_priority <= bus.wdata[`CIC_PRIORITY_CRC_SERIAL_ERR_CRC_LSB +: 3];
      serial2_error_priority <= bus.wdata[`CIC_PRIORITY_CRC_SERIAL_ERR_U2E_LSB +: 3];
      serial1_error_priority <= bus.wdata[`CIC_PRIORITY_CRC_SERIAL_ERR_U1E_LSB +: 3];
    end
  end

  // unimplemented bits are simply never stored and read back as zero
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= '0;
    else if (ce && bus.rd)
    begin
      case (bus.addr)
        `CIC_OFF_CORE_CONTROL:
          rdata <= {12'h0000, cpu_level_above_seven, program_window_enable, 2'h0};
        `CIC_OFF_INT_CONTROL_SECOND:
          rdata <= {alternate_vector_select, timed_irq_block_active, 9'h000, ext_edge_polarity};
        `CIC_OFF_PRIORITY_ADC_SERIAL_TX:
          rdata <= {9'h000, converter_done_priority, 1'b0, serial1_tx_priority};
        `CIC_OFF_PRIORITY_CRC_SERIAL_ERR:
          rdata <= {1'b0, checksum_engine_priority, 1'b0, serial2_error_priority,
                    1'b0, serial1_error_priority, 4'h0};
        default:
          rdata <= '0;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < CIC_NUM_EXT; g++)
    begin : g_ext
      cic_edge_sync u_sync
      (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin(ext_pin[g]),
        .falling(ext_edge_polarity[g]),
        .edge_seen(ext_edge[g])
      );
    end
  endgenerate

  // edge flags are sticky until reset; with no clear path nothing can race a set
  always_ff @(posedge clk)
  begin
    if (rst)
      ext_flag <= '0;
    else if (ce)
      ext_flag <= ext_flag | ext_edge;
  end

  always_comb
  begin
    src_prio[0] = converter_done_priority;
    src_prio[1] = serial1_tx_priority;
    src_prio[2] = checksum_engine_priority;
    src_prio[3] = serial2_error_priority;
    src_prio[4] = serial1_error_priority;
  end

  // lowest-numbered source wins a tie between equal levels
  always_comb
  begin
    next_req = '0;
    for (int t = NUM_TRAP - 1; t >= 0; t--)
    begin
      if (trap_flag[t])
      begin
        next_req.valid = 1'b1;
        next_req.is_trap = 1'b1;
        next_req.id = 4'(t);
        next_req.level = 3'h7;
      end
    end
    if (!next_req.valid && !cpu_level_above_seven && !timed_irq_block_active)
    begin
      for (int s = CIC_NUM_SRC - 1; s >= 0; s--)
      begin
        if (src_flag[s] && src_prio[s] != 3'h0 && src_prio[s] >= next_req.level)
        begin
          next_req.valid = 1'b1;
          next_req.id = 4'(s);
          next_req.level = src_prio[s];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      core_req <= '0;
    else if (ce)
      core_req <= next_req;
  end
endmodule : cic_core

// ---- src/cic_edge_sync.sv ----
// Purpose: pin synchroniser and polarity-selected edge detector for one external input
// Assumes: pin is asynchronous to clk
// Notes: change counts once second and third stages agree
`timescale 1ns/1ps
module cic_edge_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  input wire logic falling,
  output logic edge_seen
);
  logic s1;
  logic s2;
  logic s3;
  logic level;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else if (ce)
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // level only moves when the last two stages agree, filtering one-cycle glitches
  always_ff @(posedge clk)
  begin
    if (rst)
      level <= 1'b0;
    else if (ce && (s2 == s3))
      level <= s3;
  end

  always_comb
  begin
    if (ce && (s2 == s3) && (s3 != level))
      edge_seen = falling ? ~s3 : s3;
    else
      edge_seen = 1'b0;
  end
endmodule : cic_edge_sync

// ---- testbench/cic_core_monitor.sv ----
// Purpose: port checker for cic_core
// Assumes: one clock, rst synchronous
// Notes: bound below
`timescale 1ns/1ps
module cic_core_monitor
#(
  parameter int NUM_TRAP = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input cic_pkg::cic_bus_s bus,
  input cic_pkg::cic_word_t rdata,
  input wire logic [3:0] cpu_level,
  input wire logic [NUM_TRAP-1:0] trap_flag,
  input wire logic [cic_pkg::CIC_NUM_EXT-1:0] ext_flag,
  input wire logic program_window_enable,
  input wire logic alternate_vector_select,
  input cic_pkg::cic_req_s core_req
);
  import cic_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  cic_word_t zmask;
  // mask lines up with rdata, one cycle after the read
  always_ff @(posedge clk)
  begin
    case (bus.addr)
      4'h0: zmask <= 16'hfff3;
      4'h1: zmask <= 16'h3fe0;
      4'h2: zmask <= 16'hff88;
      4'h3: zmask <= 16'h888f;
      default: zmask <= 16'hffff;
    endcase
  end
  sequence s_hi;
    (ce && cpu_level > 4'h7 && trap_flag == '0) [*2];
  endsequence
  sequence s_rd0;
    ce && $stable(cpu_level > 4'h7) && bus.rd && bus.addr == 4'h0;
  endsequence
  property p_block;
    s_hi |=> !core_req.valid;
  endproperty
  a_block: assert property (p_block) else $error("request not blocked");
  property p_trap;
    ce && |trap_flag |=> core_req.valid && core_req.is_trap;
  endproperty
  a_trap: assert property (p_trap) else $error("trap lost");
  property p_zero;
    core_req.valid && !core_req.is_trap |-> core_req.level != 3'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("disabled source");
  property p_unimp;
    ce && bus.rd |=> (rdata & zmask) == '0;
  endproperty
  a_unimp: assert property (p_unimp) else $error("unimplemented bit set");
  property p_pwin;
    ce && bus.wr && bus.addr == 4'h0 |=> program_window_enable == $past(bus.wdata[2]);
  endproperty
  a_pwin: assert property (p_pwin) else $error("window enable wrong");
  property p_alt;
    ce && bus.wr && bus.addr == 4'h1 |=> alternate_vector_select == $past(bus.wdata[15]);
  endproperty
  a_alt: assert property (p_alt) else $error("vector select wrong");
  property p_lvl;
    s_rd0 |=> rdata[3] == $past(cpu_level > 4'h7);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level status wrong");
  property p_sticky;
    !$past(rst) |-> ($past(ext_flag) & ~ext_flag) == '0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("edge flag dropped");
endmodule : cic_core_monitor
bind cic_core cic_core_monitor #(.NUM_TRAP(NUM_TRAP)) u_cic_core_monitor
(
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .bus(bus),
  .rdata(rdata),
  .cpu_level(cpu_level),
  .trap_flag(trap_flag),
  .ext_flag(ext_flag),
  .program_window_enable(program_window_enable),
  .alternate_vector_select(alternate_vector_select),
  .core_req(core_req)
);

// ---- testbench/cic_partner.sv ----
// Purpose: cpu core and source model for cic_core
// Assumes: dly above zero gives a slow partner
// Notes: takes the bench values at the edge and shows them 1 ns later
`timescale 1ns/1ps
module cic_partner
(
  input wire logic clk,
  input wire logic [3:0] dly,
  input wire logic [3:0] lvl_i,
  input wire logic blk_i,
  input wire logic [4:0] src_i,
  input wire logic [4:0] pin_i,
  input wire logic [7:0] trap_i,
  output logic [3:0] cpu_level = '0,
  output logic timed_irq_block_active = 1'b0,
  output logic [4:0] src_flag = '0,
  output logic [4:0] ext_pin = '0,
  output logic [7:0] trap_flag = '0
);
  // slow mode refreshes only every dly+1 edges, as a busy core would
  // sampling at the edge avoids racing the bench, which also moves its values 1 ns after it
  always @(posedge clk)
  begin
    repeat (dly) @(posedge clk);
    cpu_level <= #1 lvl_i;
    timed_irq_block_active <= #1 blk_i;
    src_flag <= #1 src_i;
    ext_pin <= #1 pin_i;
    trap_flag <= #1 trap_i;
  end
endmodule : cic_partner

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for cic_core
// Assumes: partner drives core and source levels
// Notes: reads are scored through a queue
`timescale 1ns/1ps
module tb_top;
  import cic_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  cic_bus_s bus = '0;
  cic_word_t rdata, w;
  cic_req_s core_req;
  logic [3:0] dly = '0, lvl_i = '0, cpu_level;
  logic [4:0] src_i = '0, pin_i = '0, src_flag, ext_pin, ext_flag;
  logic [7:0] trap_i = '0, trap_flag, seed = 8'h26;
  logic blk_i = 1'b0, timed_irq_block_active, program_window_enable, alternate_vector_select, took;
  cic_word_t exp_q[$];
  int mismatches = 0, num_checks = 0, cycles = 0;
  cic_partner u_cic_partner
  (
    .clk(clk),
    .dly(dly),
    .lvl_i(lvl_i),
    .blk_i(blk_i),
    .src_i(src_i),
    .pin_i(pin_i),
    .trap_i(trap_i),
    .cpu_level(cpu_level),
    .timed_irq_block_active(timed_irq_block_active),
    .src_flag(src_flag),
    .ext_pin(ext_pin),
    .trap_flag(trap_flag)
  );
  cic_core u_cic_core
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .bus(bus),
    .rdata(rdata),
    .cpu_level(cpu_level),
    .timed_irq_block_active(timed_irq_block_active),
    .src_flag(src_flag),
    .ext_pin(ext_pin),
    .trap_flag(trap_flag),
    .ext_flag(ext_flag),
    .program_window_enable(program_window_enable),
    .alternate_vector_select(alternate_vector_select),
    .core_req(core_req)
  );
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lf
  function automatic cic_word_t msk(input logic [3:0] a);
    case (a)
      4'h0: return 16'h0004;
      4'h1: return 16'h801f;
      4'h2: return 16'h0077;
      4'h3: return 16'h7770;
      default: return 16'h0000;
    endcase
  endfunction : msk
  task chk(input cic_word_t got, input cic_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic wr, input logic [3:0] a, input cic_word_t d, input cic_word_t e);
    bus = '{rd: !wr, wr: wr, addr: a, wdata: d};
    if (!wr)
      exp_q.push_back(e);
    @(posedge clk);
    #1;
  endtask : acc
  task idle(input int n);
    bus = '0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task req(input logic [8:0] e, input logic [8:0] m);
    idle(3);
    chk({7'h00, core_req & m}, {7'h00, e});
  endtask : req
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // read data lands on the same edge that takes the read; it is checked 2 ns later
  always @(posedge clk)
  begin
    took = ce && bus.rd && !rst;
    #2;
    if (took)
      chk(rdata, exp_q.pop_front());
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int a = 0; a < 5; a++)
      acc(1'b0, 4'(a), '0, a == 2 ? 16'h0044 : a == 3 ? 16'h4440 : 16'h0000);
    for (int i = 0; i < 15; i++)
    begin
      seed = lf(seed);
      w = {seed, lf(seed)};
      acc(1'b1, 4'(i % 5), w, w);
      acc(1'b0, 4'(i % 5), w, w & msk(4'(i % 5)));
    end
    lvl_i = 4'h8;
    blk_i = 1'b1;
    acc(1'b1, 4'h0, 16'h0004, w);
    acc(1'b1, 4'h1, 16'h801e, w);
    idle(3);
    acc(1'b0, 4'h0, w, 16'h000c);
    acc(1'b0, 4'h1, w, 16'hc01e);
    blk_i = 1'b0;
    src_i = 5'h1f;
    req(9'h000, 9'h1ff);
    lvl_i = 4'h0;
    acc(1'b1, 4'h2, 16'h0030, w);
    acc(1'b1, 4'h3, 16'h5260, w);
    req(9'h126, 9'h1ff);
    blk_i = 1'b1;
    req(9'h000, 9'h1ff);
    blk_i = 1'b0;
    src_i = 5'h02;
    req(9'h000, 9'h1ff);
    src_i = 5'h03;
    req(9'h103, 9'h1ff);
    // with the enable low neither the write nor the new flags may move any state
    ce = 1'b0;
    src_i = 5'h1f;
    acc(1'b1, 4'h2, 16'h0070, w);
    req(9'h103, 9'h1ff);
    ce = 1'b1;
    acc(1'b0, 4'h2, w, 16'h0030);
    lvl_i = 4'h8;
    trap_i = 8'h24;
    req(9'h190, 9'h1f8);
    trap_i = 8'h00;
    lvl_i = 4'h0;
    idle(3);
    acc(1'b0, 4'h0, w, 16'h0004);
    dly = 4'h2;
    pin_i = 5'h1f;
    idle(12);
    chk(16'(ext_flag), 16'h0001);
    pin_i = 5'h00;
    idle(12);
    chk(16'(ext_flag), 16'h001f);
    // second reset in mid-run: priorities back to 4, flags cleared
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    acc(1'b0, 4'h2, w, 16'h0044);
    chk(16'(ext_flag), 16'h0000);
    req(9'h104, 9'h1ff);
    idle(2);
    print_verdict();
  end
endmodule : tb_top
